// *** logic/pcs_select_unit.sv ***
`timescale 1ns/100ps
`include "pcs_map.svh"
module pcs_select_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] cfg_data_i,
  input wire logic acc_valid_i,
  input wire logic acc_ds_i,
  input wire logic [23:0] acc_addr_i,
  input wire logic [2:0] acc_fc_i,
  input wire logic acc_rw_i,
  input wire logic [1:0] acc_size_i,
  input wire logic [2:0] acc_ipl_i,
  input wire logic acc_internal_i,
  output logic [11:0] sel_n_o,
  output logic [4:0] upper_pin_o,
  output logic [1:0] data_size_acknowledge_n_o,
  output logic autovector_request_n_o
);
  pcs_pkg::pcs_reg_t base_q [`PCS_NCS];
  pcs_pkg::pcs_reg_t opt_q [`PCS_NCS];
  pcs_pkg::pcs_state_t state_q;
  logic [13:0] pa0_q;
  logic [9:0] pa1_q;
  logic [13:0] rst_pa0;
  logic [9:0] rst_pa1;
  logic [7:0] strap_q;
  logic div_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic wr;
  logic [4:0] cs_idx;
  logic cs_adr;
  logic [11:0] hit;
  logic [11:0] hit_q;
  logic [11:0] is_sel;
  logic [11:0] port8;
  logic [11:0] act;
  logic [11:0] sel_n_q;
  logic [4:0] up_q;
  logic [4:0] cnt_q;
  logic [4:0] lim_d;
  logic [4:0] lim_q;
  logic term_d;
  logic term_q;
  logic autovector_request_d;
  logic autovector_request_q;
  logic p8_d;
  logic p8_q;
  logic sync_d;
  logic sync_q;
  logic sync_ok_q;
  logic done;
  logic [1:0] data_size_acknowledge_n_q;
  logic autovector_request_n_q;
  logic slow_peripheral_clock;
  logic slow_peripheral_clock_rise;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ---------------- reset pin-function straps ----------------
  assign rst_pa0[1:0] = cfg_data_i[0] ? `PCS_PF_SEL16 : `PCS_PF_SEL8;
  assign rst_pa0[7:2] = cfg_data_i[1] ? {3{`PCS_PF_SEL16}} : {3{`PCS_PF_ALT}};
  assign rst_pa0[13:8] = cfg_data_i[2] ? {3{`PCS_PF_SEL16}} : {3{`PCS_PF_ALT}};

  genvar k;
  generate
    for (k = 0; k < `PCS_NUP; k++) begin : g_up
      // pin k stays a select only while every controlling line at and above it is high
      assign rst_pa1[2*k+:2] = (&cfg_data_i[7:3+k]) ? `PCS_PF_SEL16 : `PCS_PF_ALT;
    end
  endgenerate

  // ---------------- wishbone slave ----------------
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign cs_idx = wb_adr_i[7:3] - `PCS_CS_IDX_OFS;
  assign cs_adr = (wb_adr_i[7:6] != 2'h0) & (cs_idx < 5'(`PCS_NCS));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // strap is sampled every reset cycle, so the value held is the one at release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= cfg_data_i;
      pa0_q <= rst_pa0;
      pa1_q <= rst_pa1;
    end else if (wr && wb_adr_i == `PCS_ADR_PA0) begin
      pa0_q <= 14'(merge16({2'h0, pa0_q}, wb_dat_i[15:0], wb_sel_i[1:0]));
    end else if (wr && wb_adr_i == `PCS_ADR_PA1) begin
      pa1_q <= 10'(merge16({6'h00, pa1_q}, wb_dat_i[15:0], wb_sel_i[1:0]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 1'b0;
    end else if (wr && wb_adr_i == `PCS_ADR_CLK && wb_sel_i[0]) begin
      div_q <= wb_dat_i[0];
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (cs_adr) begin
      rd_d[15:0] = wb_adr_i[2] ? opt_q[cs_idx[3:0]] : base_q[cs_idx[3:0]];
    end else begin
      unique case (wb_adr_i)
        `PCS_ADR_PA0: rd_d[13:0] = pa0_q;
        `PCS_ADR_PA1: rd_d[9:0] = pa1_q;
        `PCS_ADR_CLK: rd_d[0] = div_q;
        `PCS_ADR_STRAP: rd_d[7:0] = strap_q;
        `PCS_ADR_STAT: rd_d[12:0] = {state_q != pcs_pkg::PCS_IDLE, ~sel_n_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else begin
      dat_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ---------------- per-circuit registers and compare ----------------
  genvar i;
  generate
    for (i = 0; i < `PCS_NCS; i++) begin : g_cs
      logic [1:0] pf;
      if (i < `PCS_UP_FIRST) begin : g_lo
        assign pf = pa0_q[2*i+:2];
      end else begin : g_hi
        assign pf = pa1_q[2*(i-`PCS_UP_FIRST)+:2];
      end
      assign is_sel[i] = pf[1];
      assign port8[i] = pf == `PCS_PF_SEL8;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          base_q[i] <= (i == 0) ? `PCS_BASE_RST_BOOT : `PCS_REG_RST;
          opt_q[i] <= (i == 0) ? `PCS_OPT_RST_BOOT : `PCS_REG_RST;
        end else if (wr && cs_adr && cs_idx == 5'(i)) begin
          if (wb_adr_i[2]) begin
            opt_q[i] <= merge16(opt_q[i], wb_dat_i[15:0], wb_sel_i[1:0]);
          end else begin
            base_q[i] <= merge16(base_q[i], wb_dat_i[15:0], wb_sel_i[1:0]);
          end
        end
      end

      pcs_match u_match (
        .base_i(base_q[i]),
        .opt_i(opt_q[i]),
        .port8_i(port8[i]),
        .addr_i(acc_addr_i),
        .fc_i(acc_fc_i),
        .rw_i(acc_rw_i),
        .size_i(acc_size_i),
        .ipl_i(acc_ipl_i),
        .hit_o(hit[i])
      );

      // strobe choice lets a select act as output enable or read/write strobe
      assign act[i] = hit_q[i] & is_sel[i] & acc_valid_i & (state_q != pcs_pkg::PCS_IDLE) &
                      (~opt_q[i][`PCS_O_STRB] | acc_ds_i) &
                      (~opt_q[i][`PCS_O_SYNC] | sync_ok_q);
    end
  endgenerate

  // ---------------- internal termination source ----------------
  // lowest-numbered matching circuit with internal termination decides the answer
  always_comb begin
    term_d = 1'b0;
    lim_d = 5'h00;
    autovector_request_d = 1'b0;
    p8_d = 1'b0;
    sync_d = 1'b0;
    for (int n = `PCS_NCS - 1; n >= 0; n--) begin
      if (hit[n] && opt_q[n][`PCS_O_DATA_SIZE_ACKNOWLEDGE] != `PCS_DATA_SIZE_ACKNOWLEDGE_EXT) begin
        term_d = 1'b1;
        lim_d = (opt_q[n][`PCS_O_DATA_SIZE_ACKNOWLEDGE] == `PCS_DATA_SIZE_ACKNOWLEDGE_FAST) ? 5'h00 :
                5'({1'b0, opt_q[n][`PCS_O_DATA_SIZE_ACKNOWLEDGE]} + 5'h01);
        autovector_request_d = opt_q[n][`PCS_O_AUTOVECTOR_REQUEST] & (acc_fc_i == `PCS_FC_CPU);
        p8_d = port8[n];
        sync_d = opt_q[n][`PCS_O_SYNC];
      end
    end
  end

  assign done = term_q & (cnt_q >= lim_q) & (~sync_q | sync_ok_q);

  // ---------------- bus cycle sequencer ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= pcs_pkg::PCS_IDLE;
      hit_q <= 12'h000;
      cnt_q <= 5'h00;
      lim_q <= 5'h00;
      term_q <= 1'b0;
      autovector_request_q <= 1'b0;
      p8_q <= 1'b0;
      sync_q <= 1'b0;
      sync_ok_q <= 1'b0;
    end else begin
      unique case (state_q)
        pcs_pkg::PCS_IDLE: begin
          if (acc_valid_i) begin
            state_q <= pcs_pkg::PCS_RUN;
            hit_q <= acc_internal_i ? 12'h000 : hit;
            term_q <= term_d & ~acc_internal_i;
            lim_q <= lim_d;
            autovector_request_q <= autovector_request_d;
            p8_q <= p8_d;
            sync_q <= sync_d;
            cnt_q <= 5'h00;
            sync_ok_q <= 1'b0;
          end
        end
        pcs_pkg::PCS_RUN: begin
          if (!acc_valid_i) begin
            state_q <= pcs_pkg::PCS_IDLE;
            hit_q <= 12'h000;
          end else begin
            if (cnt_q != 5'h1f) begin
              cnt_q <= cnt_q + 5'h01;
            end
            if (slow_peripheral_clock_rise) begin
              sync_ok_q <= 1'b1;
            end
            if (done) begin
              state_q <= pcs_pkg::PCS_END;
            end
          end
        end
        pcs_pkg::PCS_END: begin
          if (!acc_valid_i) begin
            state_q <= pcs_pkg::PCS_IDLE;
            hit_q <= 12'h000;
          end
        end
      endcase
    end
  end

  // ---------------- registered pin drivers ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_n_q <= 12'hfff;
      data_size_acknowledge_n_q <= 2'h3;
      autovector_request_n_q <= 1'b1;
    end else begin
      sel_n_q <= ~act;
      if (state_q == pcs_pkg::PCS_RUN && acc_valid_i && done) begin
        // an 8-bit port answers on the low acknowledge line only
        data_size_acknowledge_n_q <= autovector_request_q ? 2'h3 : (p8_q ? 2'h2 : 2'h0);
        autovector_request_n_q <= ~autovector_request_q;
      end else if (!acc_valid_i) begin
        data_size_acknowledge_n_q <= 2'h3;
        autovector_request_n_q <= 1'b1;
      end
    end
  end

  // address pins follow the bus one clock late; fine for a latched address bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_q <= 5'h1f;
    end else begin
      for (int u = 0; u < `PCS_NUP; u++) begin
        unique case (pa1_q[2*u+:2])
          `PCS_PF_SEL16, `PCS_PF_SEL8: up_q[u] <= sel_n_q[`PCS_UP_FIRST+u];
          `PCS_PF_ALT: up_q[u] <= acc_addr_i[`PCS_ADDR_UP_LO+u];
          `PCS_PF_DISC: up_q[u] <= (u == `PCS_NUP - 1) ? slow_peripheral_clock : 1'b1;
        endcase
      end
    end
  end

  pcs_clkdiv u_clkdiv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div16_i(div_q),
    .slow_peripheral_clock_o(slow_peripheral_clock),
    .rise_o(slow_peripheral_clock_rise)
  );

  assign sel_n_o = sel_n_q | ~is_sel;
  assign upper_pin_o = up_q;
  assign data_size_acknowledge_n_o = data_size_acknowledge_n_q;
  assign autovector_request_n_o = autovector_request_n_q;
endmodule // pcs_select_unit

// *** logic/pcs_map.svh ***
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

`define PCS_NCS 12
`define PCS_NUP 5
`define PCS_UP_FIRST 7
`define PCS_ADR_PA0 8'h00
`define PCS_ADR_PA1 8'h04
`define PCS_ADR_CLK 8'h08
`define PCS_ADR_STRAP 8'h0c
`define PCS_ADR_STAT 8'h10
`define PCS_CS_IDX_OFS 5'd8
`define PCS_BASE_RST_BOOT 16'h0006
`define PCS_OPT_RST_BOOT 16'h7b70
`define PCS_REG_RST 16'h0000
`define PCS_B_ADDR 15:3
`define PCS_B_SIZE 2:0
`define PCS_O_SYNC 15
`define PCS_O_BYTE 14:13
`define PCS_O_WR 12
`define PCS_O_RD 11
`define PCS_O_STRB 10
`define PCS_O_DATA_SIZE_ACKNOWLEDGE 9:6
`define PCS_O_SPACE 5:4
`define PCS_O_IPL 3:1
`define PCS_O_AUTOVECTOR_REQUEST 0
`define PCS_DATA_SIZE_ACKNOWLEDGE_FAST 4'he
`define PCS_DATA_SIZE_ACKNOWLEDGE_EXT 4'hf
`define PCS_FC_CPU 3'h7
`define PCS_SIZE_BYTE 2'h1
`define PCS_SP_CPU 2'h0
`define PCS_SP_USER 2'h1
`define PCS_SP_SUPV 2'h2
`define PCS_SP_BOTH 2'h3
`define PCS_PF_SEL16 2'h3
`define PCS_PF_SEL8 2'h2
`define PCS_PF_ALT 2'h1
`define PCS_PF_DISC 2'h0
`define PCS_SLOW_PERIPHERAL_CLOCK_HALF8 4'h3
`define PCS_SLOW_PERIPHERAL_CLOCK_HALF16 4'h7
`define PCS_ADDR_UP_LO 19

`endif

// *** logic/pcs_pkg.sv ***
package pcs_pkg;
  typedef enum logic [1:0] {PCS_IDLE, PCS_RUN, PCS_END} pcs_state_t;
  typedef logic [15:0] pcs_reg_t;
endpackage

// *** logic/pcs_clkdiv.sv ***
`timescale 1ns/100ps
`include "pcs_map.svh"
module pcs_clkdiv (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic div16_i,
  output logic slow_peripheral_clock_o,
  output logic rise_o
);
  logic [3:0] cnt_q;
  logic slow_peripheral_clock_q;
  logic [3:0] half;

  assign half = div16_i ? `PCS_SLOW_PERIPHERAL_CLOCK_HALF16 : `PCS_SLOW_PERIPHERAL_CLOCK_HALF8;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      slow_peripheral_clock_q <= 1'b0;
    end else if (cnt_q >= half) begin
      cnt_q <= 4'h0;
      slow_peripheral_clock_q <= ~slow_peripheral_clock_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign slow_peripheral_clock_o = slow_peripheral_clock_q;
  // one-cycle pulse in the cycle before the clock goes high
  assign rise_o = (cnt_q >= half) & ~slow_peripheral_clock_q;
endmodule // pcs_clkdiv

// *** logic/pcs_match.sv ***
`timescale 1ns/100ps
`include "pcs_map.svh"
module pcs_match (
  input wire logic [15:0] base_i,
  input wire logic [15:0] opt_i,
  input wire logic port8_i,
  input wire logic [23:0] addr_i,
  input wire logic [2:0] fc_i,
  input wire logic rw_i,
  input wire logic [1:0] size_i,
  input wire logic [2:0] ipl_i,
  output logic hit_o
);
  logic [12:0] mask;
  logic addr_ok;
  logic byte_ok;
  logic rw_ok;
  logic sp_ok;
  logic cpu;
  logic [1:0] byt;

  always_comb begin
    unique case (base_i[`PCS_B_SIZE])
      3'h0: mask = 13'h1fff;
      3'h1: mask = 13'h1ffc;
      3'h2: mask = 13'h1ff8;
      3'h3: mask = 13'h1fe0;
      3'h4: mask = 13'h1fc0;
      3'h5: mask = 13'h1f80;
      3'h6: mask = 13'h1f00;
      3'h7: mask = 13'h1e00;
    endcase
  end

  // base bits below the block size are ignored, so a misaligned base just aliases
  assign addr_ok = ((addr_i[23:11] ^ base_i[`PCS_B_ADDR]) & mask) == 13'h0000;
  assign byt = opt_i[`PCS_O_BYTE];
  assign byte_ok = port8_i ? (byt != 2'h0) :
                   ((byt[1] & ~addr_i[0]) |
                    (byt[0] & (addr_i[0] | (size_i != `PCS_SIZE_BYTE))));
  assign rw_ok = rw_i ? opt_i[`PCS_O_RD] : opt_i[`PCS_O_WR];
  assign cpu = fc_i == `PCS_FC_CPU;

  always_comb begin
    unique case (opt_i[`PCS_O_SPACE])
      `PCS_SP_CPU: sp_ok = cpu & ((opt_i[`PCS_O_IPL] == 3'h0) | (opt_i[`PCS_O_IPL] == ipl_i));
      `PCS_SP_USER: sp_ok = ~fc_i[2] & ~cpu;
      `PCS_SP_SUPV: sp_ok = fc_i[2] & ~cpu;
      `PCS_SP_BOTH: sp_ok = ~cpu;
    endcase
  end

  assign hit_o = addr_ok & byte_ok & rw_ok & sp_ok;
endmodule // pcs_match

// *** verif/pcs_ext_dev.sv ***
`timescale 1ns/100ps
module pcs_ext_dev (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [11:0] sel_n_i,
  output logic [11:0] seen_o
);
  // a device only answers while its line is low, so a stuck-high select goes unseen
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      seen_o <= 12'h000;
    end else begin
      seen_o <= seen_o | ~sel_n_i;
    end
  end
endmodule // pcs_ext_dev

// *** verif/pcs_select_unit_monitor.sv ***
`timescale 1ns/100ps
module pcs_select_unit_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic acc_valid_i,
  input wire logic acc_ds_i,
  input wire logic acc_internal_i,
  input wire logic [11:0] sel_n_o,
  input wire logic [4:0] upper_pin_o,
  input wire logic [1:0] data_size_acknowledge_n_o,
  input wire logic autovector_request_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_open;
    !acc_valid_i ##1 acc_valid_i && acc_internal_i;
  endsequence
  sequence s_quiet;
    &sel_n_o && &data_size_acknowledge_n_o && autovector_request_n_o;
  endsequence
  property p_rst_idle;
    $fell(rst_i) |-> &sel_n_o && &data_size_acknowledge_n_o && &upper_pin_o && !wb_ack_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus request not acknowledged");
  property p_wb_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_pulse: assert property (p_wb_pulse) else $error("acknowledge longer than one cycle");
  property p_wb_quiet;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_wb_quiet: assert property (p_wb_quiet) else $error("acknowledge without request");
  property p_release;
    !acc_valid_i |=> s_quiet;
  endproperty
  a_release: assert property (p_release) else $error("select outlives bus cycle");
  property p_internal;
    s_open |=> s_quiet [*3];
  endproperty
  a_internal: assert property (p_internal) else $error("select on internal access");
  property p_sel_cause;
    $fell(&sel_n_o) |-> $past(acc_valid_i, 1) && $past(acc_valid_i, 2)
      && !$past(acc_internal_i, 2);
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("select too early");
  property p_ack_cause;
    $fell(&data_size_acknowledge_n_o) |-> $past(acc_valid_i, 1) && $past(acc_valid_i, 2)
      && !$past(acc_internal_i, 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge too early");
  property p_sel_hold;
    acc_valid_i && acc_ds_i && !(&sel_n_o) |=> !(&sel_n_o);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select dropped mid cycle");
  property p_ack_code;
    data_size_acknowledge_n_o != 2'b01;
  endproperty
  a_ack_code: assert property (p_ack_code) else $error("bad port size code");
endmodule // pcs_select_unit_monitor

bind pcs_select_unit pcs_select_unit_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .acc_valid_i(acc_valid_i),
  .acc_ds_i(acc_ds_i),
  .acc_internal_i(acc_internal_i), .sel_n_o(sel_n_o), .upper_pin_o(upper_pin_o),
  .data_size_acknowledge_n_o(data_size_acknowledge_n_o),
  .autovector_request_n_o(autovector_request_n_o));

// *** verif/test_programmable_chip_select_unit.sv ***
`timescale 1ns/100ps
module test_programmable_chip_select_unit;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, valid, ds, rw, intl, avn;
  logic [7:0] adr, cfg;
  logic [3:0] wsel;
  logic [31:0] wdat, rdat;
  logic [23:0] aadr;
  logic [2:0] fc, ipl;
  logic [1:0] asz, dsk;
  logic [11:0] sel_n, seen;
  logic [4:0] upin;
  logic [15:0] base_m [12];
  logic [15:0] opt_m [12];
  logic [15:0] pa0_m, pa1_m;
  logic [23:0] addr_q [$];
  logic [7:0] rnd = 8'h43;
  int szsh [8] = '{11, 13, 14, 16, 17, 18, 19, 20};
  int n_fail = 0;
  int total_checks = 0;

  always #10 clk_i = ~clk_i;

  pcs_select_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cfg_data_i(cfg), .acc_valid_i(valid), .acc_ds_i(ds), .acc_addr_i(aadr),
    .acc_fc_i(fc), .acc_rw_i(rw), .acc_size_i(asz), .acc_ipl_i(ipl), .acc_internal_i(intl),
    .sel_n_o(sel_n), .upper_pin_o(upin), .data_size_acknowledge_n_o(dsk),
    .autovector_request_n_o(avn));
  pcs_ext_dev u_dev (.clk_i(clk_i), .clr_i(!valid), .sel_n_i(sel_n), .seen_o(seen));

  task automatic stop_test;
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cyc(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      n_fail++;
      $display("ERROR %0t cycle %0d expected %0d", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    wsel <= 4'h3;
    // no cycle count is assumed; only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, a, 16'h0000, q);
    cmp_val(q, {16'h0000, e});
  endtask

  task automatic wcfg(input int n, input logic [15:0] b, input logic [15:0] o);
    wr(8'h40 + 8'(8 * n), b);
    wr(8'h44 + 8'(8 * n), o);
    base_m[n] = b;
    opt_m[n] = o;
  endtask

  function automatic void model(input logic [23:0] a, input logic i, output logic [11:0] s,
                                output int lat);
    int sh;
    logic [1:0] pf;
    logic m;
    s = 12'hfff;
    lat = -1;
    for (int n = 0; n < 12; n++) begin
      sh = szsh[base_m[n][2:0]];
      pf = (n < 7) ? pa0_m[2 * n +: 2] : pa1_m[2 * (n - 7) +: 2];
      m = !i && opt_m[n][14:13] != 2'b00
          && (a >> sh) == ({base_m[n][15:3], 11'h000} >> sh);
      if (m && pf[1]) begin
        s[n] = 1'b0;
      end
      // a matching circuit terminates internally even when its pin is not a select
      if (m && lat < 0 && opt_m[n][9:6] != 4'hf) begin
        lat = (opt_m[n][9:6] == 4'he) ? 2 : 3 + int'(opt_m[n][9:6]);
      end
    end
  endfunction

  // the access is held a fixed 20 cycles so the longest wait-state count still lands inside
  task automatic acc(input logic [23:0] a, input logic i);
    logic [11:0] es;
    logic [1:0] dv;
    logic av;
    int el, ks, ka;
    model(a, i, es, el);
    ks = -1;
    ka = -1;
    dv = 2'b11;
    av = 1'b1;
    rnd = lfsr(rnd);
    @(posedge clk_i);
    valid <= 1'b1;
    aadr <= a;
    intl <= i;
    fc <= {rnd[0], 2'b01};
    rw <= rnd[1];
    for (int k = 1; k <= 20; k++) begin
      @(posedge clk_i);
      #1;
      if (ks < 0 && sel_n !== 12'hfff) ks = k;
      if (ka < 0 && dsk !== 2'b11) begin
        ka = k;
        dv = dsk;
        av = avn;
      end
    end
    cmp_val({20'h00000, seen}, {20'h00000, ~es});
    for (int u = 0; u < 5; u++) begin
      if (pa1_m[2 * u +: 2] == 2'b01) begin
        cmp_val({31'h0, upin[u]}, {31'h0, a[19 + u]});
      end else if (pa1_m[2 * u + 1]) begin
        cmp_val({31'h0, upin[u]}, {31'h0, es[7 + u]});
      end
    end
    cmp_cyc(ks, (es == 12'hfff) ? -1 : 2);
    cmp_val({31'h0, av}, 32'h1);
    cmp_cyc(ka, el);
    if (el > 0) begin
      cmp_val({30'h0, dv}, 32'h0);
    end
    @(posedge clk_i);
    valid <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic slow_peripheral_clock_half(input int e);
    logic p;
    int c;
    for (int t = 0; t < 3; t++) begin
      c = 0;
      @(posedge clk_i);
      #1;
      p = upin[4];
      while (upin[4] === p && c < 40) begin
        @(posedge clk_i);
        #1;
        c++;
      end
    end
    cmp_cyc(c + 1, e);
  endtask

  initial begin
    repeat (4000) @(posedge clk_i);
    n_fail++;
    stop_test;
  end

  initial begin
    {cyc, stb, we, valid, intl} = 5'h00;
    {adr, wsel, wdat, aadr} = '0;
    {ds, rw, fc, asz, ipl} = {1'b1, 1'b1, 3'h5, 2'h2, 3'h0};
    cfg = lfsr(rnd) | 8'h03;
    for (int n = 0; n < 12; n++) begin
      base_m[n] = 16'h0000;
      opt_m[n] = 16'h0000;
    end
    base_m[0] = 16'h0006;
    opt_m[0] = 16'h7b70;
    pa0_m = {2'b00, {3{cfg[2] ? 2'b11 : 2'b01}}, {3{cfg[1] ? 2'b11 : 2'b01}},
             cfg[0] ? 2'b11 : 2'b10};
    pa1_m = 16'h0000;
    for (int k = 0; k < 5; k++) begin
      pa1_m[2 * k +: 2] = ((cfg >> (3 + k)) == (8'hff >> (3 + k))) ? 2'b11 : 2'b01;
    end
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h0c, {8'h00, cfg});
    rd_chk(8'h00, pa0_m);
    rd_chk(8'h04, pa1_m);
    rd_chk(8'h40, 16'h0006);
    rd_chk(8'h44, 16'h7b70);
    rd_chk(8'h4c, 16'h0000);
    wr(8'h0c, 16'h00ff);
    rd_chk(8'h0c, {8'h00, cfg});
    rd_chk(8'hfc, 16'h0000);
    acc(24'h000100, 1'b0);
    acc(24'h07fffe, 1'b0);
    acc(24'h080000, 1'b0);
    acc(24'h000200, 1'b1);
    wr(8'h00, 16'h3fff);
    wr(8'h04, 16'h03ff);
    pa0_m = 16'h3fff;
    pa1_m = 16'h03ff;
    rd_chk(8'h00, 16'h3fff);
    wcfg(1, 16'h0000, 16'h7bb0);
    wcfg(2, 16'h0800, 16'h7bb0);
    addr_q = '{24'h000100, 24'h0807ff, 24'h080800, {5'h01, rnd[5:0], 13'h0000}};
    foreach (addr_q[k]) acc(addr_q[k], 1'b0);
    wr(8'h04, 16'h00ff);
    slow_peripheral_clock_half(4);
    wr(8'h08, 16'h0001);
    slow_peripheral_clock_half(8);
    stop_test;
  end
endmodule // test_programmable_chip_select_unit
